// ==== hdl/cdp_core.sv ====
// Processor core: fetch, register file, ALU, multiplier and stack
`timescale 1ns/1ps
`include "cdp_consts.svh"

//
// Contract
// - Fetch starts at word 0; program counter holds next fetch address.
// - Separate program and data buses, usable in the same cycle.
// - One-stage prefetch: next word fetched while current one executes.
// - Runs on the core clock directly; one cycle per instruction except multiply, pop, calls, returns, jumps and taken branches.
// - Register and immediate ALU operations finish in one cycle, written back except compare.
// - Arithmetic, logic, bit and single-register ops, 8- and 16-bit adds.
// - Status flags updated after every arithmetic or logic operation.
// - 8x8 multiply to 16 bits, signed, unsigned, mixed, integer or fractional.
// - Each multiply takes exactly two clock cycles.
// - Mostly one-word instructions, plus a two-word absolute jump.
// - Calls and interrupts save the return word address on the stack.
// - Reset loads the stack pointer with the top SRAM address.
// - Stack pointer is two byte registers, readable and writable by software.
// - Stack grows down; byte push decrements by 1, pop increments by 1.
// - Calls and interrupt entry push two bytes; returns pop two bytes.
// - Return address low byte goes first, at the higher address.
// - Status flags are not saved or restored on interrupt entry or exit.
// - Low stack byte write blocks interrupts four instructions or until I/O write.
// - Thirty-two 8-bit working registers, separate from data memory.
module cdp_core (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    output logic [15:0]      prog_addr_o,
    input  wire logic [15:0] prog_data_i,
    output logic [15:0]      data_addr_o,
    output logic [7:0]       data_wdata_o,
    output logic             data_we_o,
    output logic             data_re_o,
    input  wire logic [7:0]  data_rdata_i,
    input  wire logic        irq_req_i,
    input  wire logic [7:0]  irq_vector_i,
    output logic             irq_ack_o,
    output logic [7:0]       status_flag_register_o,
    output logic [15:0]      stack_pointer_o
);
    import cdp_pkg::*;

    function automatic logic is_misc(input logic [15:0] ir, input logic [3:0] code);
        is_misc = (ir[15:14] == `CDP_CLS_MISC) && (ir[13:10] == code);
    endfunction

    function automatic logic [7:0] cdp_flags(input logic [7:0] old, input logic [7:0] r,
                                             input logic c, input logic v);
        cdp_flags = old;
        cdp_flags[`CDP_FLG_C] = c;
        cdp_flags[`CDP_FLG_Z] = (r == 8'h00);
        cdp_flags[`CDP_FLG_N] = r[7];
        cdp_flags[`CDP_FLG_V] = v;
        cdp_flags[`CDP_FLG_S] = r[7] ^ v;
    endfunction

    logic [7:0]  rf_q [32];
    logic [15:0] program_counter_q;
    logic [15:0] stack_pointer_q;
    logic [7:0]  status_flag_register_q;
    logic [15:0] ir_q;
    logic        ir_v_q;
    cdp_state_t  st_q;
    logic [15:0] ra_q;
    logic [15:0] tgt_q;
    logic [7:0]  ret_hi_q;
    logic [4:0]  pop_dst_q;
    logic [15:0] mul_q;
    logic        mul_c_q;
    logic [2:0]  blk_q;
    logic        ack_q;
    logic [15:0] d_addr_q;
    logic [7:0]  d_wd_q;
    logic        d_we_q;
    logic        d_re_q;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0]  cls;
    logic [3:0]  op4;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [4:0]  dst;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic        cin;
    logic        take_irq;
    logic        exec;
    logic        is_mul;
    logic        do_call;
    logic        do_ret;
    logic        do_push;
    logic        do_pop;
    logic [15:0] call_tgt;

    assign cls      = ir_q[15:14];
    assign op4      = ir_q[13:10];
    assign rd       = ir_q[9:5];
    assign rr       = ir_q[4:0];
    assign dst      = (cls == `CDP_CLS_IMM) ? {1'b1, ir_q[11:8]} : rd;
    assign opa      = rf_q[dst];
    assign opb      = (cls == `CDP_CLS_IMM) ? ir_q[7:0] : rf_q[rr];
    assign cin      = status_flag_register_q[`CDP_FLG_C];
    // Interrupts only between instructions, never inside a blocked window
    assign take_irq = (st_q == ST_EXEC) && ir_v_q && irq_req_i && (blk_q == 3'h0)
                    && status_flag_register_q[`CDP_FLG_I];
    assign exec     = (st_q == ST_EXEC) && ir_v_q && !take_irq;
    assign is_mul   = exec && (cls == `CDP_CLS_RR) && (op4 >= OP_MUL);
    assign do_call  = exec && ((cls == `CDP_CLS_CALL) || is_misc(ir_q, MO_CALL_IND));
    assign do_ret   = exec && (is_misc(ir_q, MO_RET_SUB) || is_misc(ir_q, MO_RET_INT));
    assign do_push  = exec && is_misc(ir_q, MO_PUSH);
    assign do_pop   = exec && is_misc(ir_q, MO_POP);
    // Relative target counts from the word after the call
    assign call_tgt = (cls == `CDP_CLS_CALL) ? program_counter_q + {{2{ir_q[13]}}, ir_q[13:0]}
                                              : {rf_q[31], rf_q[30]};

    ////////////////////////////////////////////////////////////////////////////
    logic        rf_we;
    logic [4:0]  rf_wa;
    logic [7:0]  rf_wd;
    logic        hi_we;
    logic [7:0]  hi_wd;
    logic [7:0]  fl_d;

    always_comb begin
        logic [8:0]  t;
        logic [16:0] w;
        logic        v;
        t     = 9'h000;
        w     = 17'h00000;
        v     = 1'b0;
        rf_we = 1'b0;
        rf_wa = dst;
        rf_wd = 8'h00;
        hi_we = 1'b0;
        hi_wd = 8'h00;
        fl_d  = status_flag_register_q;
        if (exec && (cls == `CDP_CLS_RR) && !is_mul) begin
            case (op4)
                OP_ADD, OP_ADC: begin
                    t = {1'b0, opa} + {1'b0, opb} + {8'h00, cin & op4[0]};
                    v = (opa[7] == opb[7]) && (t[7] != opa[7]);
                end
                OP_SUB, OP_SBC, OP_CMP: begin
                    t = {1'b0, opa} - {1'b0, opb} - {8'h00, cin & op4[0]};
                    v = (opa[7] != opb[7]) && (t[7] != opa[7]);
                end
                OP_AND:  t = {cin, opa & opb};
                OP_OR:   t = {cin, opa | opb};
                OP_XOR:  t = {cin, opa ^ opb};
                default: t = {cin, opb};
            endcase
            rf_we = (op4 != OP_CMP);
            rf_wd = t[7:0];
            if (op4 == OP_ADDW) begin
                // 16-bit add of a small constant to a register pair
                w     = {1'b0, rf_q[5'(dst + 5'h01)], opa} + {12'h000, rr};
                rf_wd = w[7:0];
                hi_we = 1'b1;
                hi_wd = w[15:8];
                fl_d  = cdp_flags(status_flag_register_q, w[15:8], w[16], 1'b0);
                fl_d[`CDP_FLG_Z] = (w[15:0] == 16'h0000);
            end else if (op4 != OP_MOV) begin
                fl_d = cdp_flags(status_flag_register_q, t[7:0], t[8], v);
            end
        end else if (exec && (cls == `CDP_CLS_IMM)) begin
            case (op4[3:2])
                2'h0: begin
                    t = {1'b0, opa} - {1'b0, opb};
                    v = (opa[7] != opb[7]) && (t[7] != opa[7]);
                end
                2'h1:    t = {cin, opa & opb};
                2'h2:    t = {cin, opa | opb};
                default: t = {cin, opb};
            endcase
            rf_we = 1'b1;
            rf_wd = t[7:0];
            if (op4[3:2] != 2'h3) begin
                fl_d = cdp_flags(status_flag_register_q, t[7:0], t[8], v);
            end
        end else if (exec && (cls == `CDP_CLS_MISC) && (op4 <= MO_LSR)) begin
            case (op4)
                MO_INC: begin
                    t = {cin, 8'(opa + 8'h01)};
                    v = (opa == 8'h7f);
                end
                MO_DEC: begin
                    t = {cin, 8'(opa - 8'h01)};
                    v = (opa == 8'h80);
                end
                MO_COM:  t = {1'b1, ~opa};
                default: begin
                    t = {opa[0], 1'b0, opa[7:1]};
                    v = opa[0];
                end
            endcase
            rf_we = 1'b1;
            rf_wd = t[7:0];
            fl_d  = cdp_flags(status_flag_register_q, t[7:0], t[8], v);
        end else if (exec && (is_misc(ir_q, MO_RD_STK_LO) || is_misc(ir_q, MO_RD_STK_HI))) begin
            rf_we = 1'b1;
            rf_wd = op4[0] ? stack_pointer_q[7:0] : stack_pointer_q[15:8];
        end else if (st_q == ST_POPW) begin
            rf_we = 1'b1;
            rf_wa = pop_dst_q;
            rf_wd = data_rdata_i;
        end else if (st_q == ST_MUL2) begin
            rf_we = 1'b1;
            rf_wa = 5'h00;
            rf_wd = mul_q[7:0];
            hi_we = 1'b1;
            hi_wd = mul_q[15:8];
            fl_d[`CDP_FLG_C] = mul_c_q;
            fl_d[`CDP_FLG_Z] = (mul_q == 16'h0000);
        end
    end

    // Register file: one byte port plus a pair port for 16-bit results
    always_ff @(posedge ref_clk_i) begin
        if (rf_we) begin
            rf_q[rf_wa] <= rf_wd;
        end
        if (hi_we) begin
            rf_q[5'(rf_wa + 5'h01)] <= hi_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic        sa;
    logic        sb;
    logic signed [17:0] prod;

    assign sa   = opa[7] && (op4 == OP_MULS || op4 == OP_MULSU || op4 == OP_FMULS
                             || op4 == OP_FMULSU);
    assign sb   = opb[7] && (op4 == OP_MULS || op4 == OP_FMULS);
    assign prod = $signed({sa, opa}) * $signed({sb, opb});

    // Product is registered here and written to the pair in the second cycle
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mul_q   <= 16'h0000;
            mul_c_q <= 1'b0;
        end else if (is_mul) begin
            mul_q   <= (op4 >= OP_FMUL) ? {prod[14:0], 1'b0} : prod[15:0];
            mul_c_q <= prod[15];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fetch and sequencing
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            program_counter_q <= `CDP_RESET_PC;
            ir_q              <= 16'h0000;
            ir_v_q            <= 1'b0;
            st_q              <= ST_EXEC;
            ra_q              <= 16'h0000;
            tgt_q             <= 16'h0000;
            ret_hi_q          <= 8'h00;
            pop_dst_q         <= 5'h00;
            ack_q             <= 1'b0;
        end else begin
            ack_q <= 1'b0;
            case (st_q)
                ST_EXEC: begin
                    if (take_irq) begin
                        // Interrupted word has not run, so it is the return point
                        ra_q   <= program_counter_q - 16'h0001;
                        tgt_q  <= {8'h00, irq_vector_i};
                        ack_q  <= 1'b1;
                        st_q   <= ST_CALL2;
                        ir_v_q <= 1'b0;
                    end else if (do_call) begin
                        ra_q   <= program_counter_q;
                        tgt_q  <= call_tgt;
                        st_q   <= ST_CALL2;
                        ir_v_q <= 1'b0;
                    end else if (do_ret) begin
                        st_q   <= ST_RET2;
                        ir_v_q <= 1'b0;
                    end else if (exec && is_misc(ir_q, MO_JMP)) begin
                        program_counter_q <= prog_data_i;
                        ir_v_q            <= 1'b0;
                    end else if (exec && is_misc(ir_q, MO_BRSET)
                                 && status_flag_register_q[rr[2:0]]) begin
                        program_counter_q <= program_counter_q + {{11{rd[4]}}, rd};
                        ir_v_q            <= 1'b0;
                    end else begin
                        ir_q              <= prog_data_i;
                        ir_v_q            <= 1'b1;
                        program_counter_q <= program_counter_q + 16'h0001;
                        if (is_mul) begin
                            st_q <= ST_MUL2;
                        end
                        if (do_pop) begin
                            st_q      <= ST_POPW;
                            pop_dst_q <= rd;
                        end
                    end
                end
                ST_CALL2: begin
                    program_counter_q <= tgt_q;
                    st_q              <= ST_EXEC;
                end
                ST_RET2: begin
                    ret_hi_q <= data_rdata_i;
                    st_q     <= ST_RET3;
                end
                ST_RET3: begin
                    program_counter_q <= {ret_hi_q, data_rdata_i};
                    st_q              <= ST_EXEC;
                end
                default: st_q <= ST_EXEC;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data bus: pushes write at the pointer, pops read one above it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            d_we_q   <= 1'b0;
            d_re_q   <= 1'b0;
            d_addr_q <= 16'h0000;
            d_wd_q   <= 8'h00;
        end else begin
            d_we_q <= 1'b0;
            d_re_q <= 1'b0;
            if (take_irq || do_call) begin
                d_we_q   <= 1'b1;
                d_addr_q <= stack_pointer_q;
                d_wd_q   <= take_irq ? 8'(program_counter_q - 16'h0001)
                                     : program_counter_q[7:0];
            end else if (do_push) begin
                d_we_q   <= 1'b1;
                d_addr_q <= stack_pointer_q;
                d_wd_q   <= opa;
            end else if (do_pop || do_ret || st_q == ST_RET2) begin
                d_re_q   <= 1'b1;
                d_addr_q <= stack_pointer_q + 16'h0001;
            end else if (st_q == ST_CALL2) begin
                d_we_q   <= 1'b1;
                d_addr_q <= stack_pointer_q;
                d_wd_q   <= ra_q[15:8];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            stack_pointer_q <= `CDP_SRAM_TOP;
        end else if (take_irq || do_call || do_push || st_q == ST_CALL2) begin
            stack_pointer_q <= stack_pointer_q - 16'h0001;
        end else if (do_pop || do_ret || st_q == ST_RET2) begin
            stack_pointer_q <= stack_pointer_q + 16'h0001;
        end else if (exec && is_misc(ir_q, MO_WR_STK_LO)) begin
            stack_pointer_q[7:0] <= opa;
        end else if (exec && is_misc(ir_q, MO_WR_STK_HI)) begin
            stack_pointer_q[15:8] <= opa;
        end
    end

    // Flags stay untouched by entry and exit apart from the enable bit
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            status_flag_register_q <= 8'h00;
        end else begin
            status_flag_register_q <= fl_d;
            if (take_irq) begin
                status_flag_register_q[`CDP_FLG_I] <= 1'b0;
            end else if (exec && (is_misc(ir_q, MO_RET_INT) || is_misc(ir_q, MO_SEI))) begin
                status_flag_register_q[`CDP_FLG_I] <= 1'b1;
            end
        end
    end

    // Counts executed instructions; the high byte write is the next I/O write
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            blk_q <= 3'h0;
        end else if (exec && is_misc(ir_q, MO_WR_STK_LO)) begin
            blk_q <= `CDP_BLK_COUNT;
        end else if (exec && blk_q != 3'h0) begin
            blk_q <= is_misc(ir_q, MO_WR_STK_HI) ? 3'h0 : blk_q - 3'h1;
        end
    end

    assign prog_addr_o            = program_counter_q;
    assign data_addr_o            = d_addr_q;
    assign data_wdata_o           = d_wd_q;
    assign data_we_o              = d_we_q;
    assign data_re_o              = d_re_q;
    assign irq_ack_o              = ack_q;
    assign status_flag_register_o = status_flag_register_q;
    assign stack_pointer_o        = stack_pointer_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_call_start;
        take_irq || do_call;
    endsequence
    sequence s_mul_issue;
        is_mul;
    endsequence

    chk_reset_pc:    assert property ($past(reset_i) |-> program_counter_q == `CDP_RESET_PC)
        else $error("pc not at reset address");
    chk_reset_stack: assert property ($past(reset_i) |-> stack_pointer_q == `CDP_SRAM_TOP)
        else $error("stack pointer not at top after reset");
    chk_mul_two:     assert property (s_mul_issue |=> st_q == ST_MUL2 ##1
        (st_q == ST_EXEC && {rf_q[1], rf_q[0]} == $past(mul_q)))
        else $error("multiply result not written in two cycles");
    chk_push_order:  assert property (do_push |=> d_we_q && d_addr_q == $past(stack_pointer_q)
        && stack_pointer_q == $past(stack_pointer_q) - 16'h0001)
        else $error("push order wrong");
    chk_pop_order:   assert property (do_pop |=> d_re_q
        && d_addr_q == $past(stack_pointer_q) + 16'h0001 && stack_pointer_q == d_addr_q)
        else $error("pop order wrong");
    chk_call_bytes:  assert property (s_call_start |=> (d_we_q && d_addr_q == $past(stack_pointer_q))
        ##1 (d_we_q && d_addr_q == $past(d_addr_q) - 16'h0001
        && stack_pointer_q == $past(stack_pointer_q, 2) - 16'h0002))
        else $error("return address push wrong");
    chk_ret_pair:    assert property (do_ret |-> ##3
        (stack_pointer_q == $past(stack_pointer_q, 3) + 16'h0002 && st_q == ST_EXEC))
        else $error("return did not pop two bytes");
    chk_irq_block:   assert property (irq_ack_o |-> $past(blk_q) == 3'h0 && blk_q <= `CDP_BLK_COUNT)
        else $error("interrupt taken in blocked window");
    chk_irq_flags:   assert property (irq_ack_o |-> status_flag_register_q[6:0]
        == $past(status_flag_register_q[6:0]))
        else $error("flags changed on interrupt entry");
    chk_add_one:     assert property (exec && cls == `CDP_CLS_RR && op4 == OP_ADD |=>
        rf_q[$past(dst)] == 8'($past(opa) + $past(opb))
        && status_flag_register_q[`CDP_FLG_Z] == (rf_q[$past(dst)] == 8'h00))
        else $error("add result or zero flag wrong");

endmodule

// ==== include/cdp_consts.svh ====
// Constants for the 8-bit processor core datapath and stack
`ifndef CDP_CONSTS_SVH
`define CDP_CONSTS_SVH
`define CDP_RESET_PC   16'h0000
`define CDP_SRAM_TOP   16'h3fff
`define CDP_BLK_COUNT  3'h4
`define CDP_MUL_CYCLES 2
// Flag positions in the status flag register
`define CDP_FLG_C 0
`define CDP_FLG_Z 1
`define CDP_FLG_N 2
`define CDP_FLG_V 3
`define CDP_FLG_S 4
`define CDP_FLG_I 7
// Instruction classes, bits 15:14
`define CDP_CLS_RR   2'h0
`define CDP_CLS_IMM  2'h1
`define CDP_CLS_MISC 2'h2
`define CDP_CLS_CALL 2'h3
`endif

// ==== include/cdp_pkg.sv ====
// Types shared by the processor core datapath
package cdp_pkg;
    typedef enum logic [2:0] {
        ST_EXEC  = 3'h0,
        ST_MUL2  = 3'h1,
        ST_CALL2 = 3'h2,
        ST_RET2  = 3'h3,
        ST_RET3  = 3'h4,
        ST_POPW  = 3'h5
    } cdp_state_t;
    // Register-register operations, bits 13:10 of class RR
    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_ADC = 4'h1, OP_SUB = 4'h2, OP_SBC = 4'h3,
        OP_AND = 4'h4, OP_OR = 4'h5, OP_XOR = 4'h6, OP_MOV = 4'h7,
        OP_CMP = 4'h8, OP_ADDW = 4'h9, OP_MUL = 4'ha, OP_MULS = 4'hb,
        OP_MULSU = 4'hc, OP_FMUL = 4'hd, OP_FMULS = 4'he, OP_FMULSU = 4'hf
    } cdp_rrop_t;
    // Single-register and flow operations, bits 13:10 of class MISC
    typedef enum logic [3:0] {
        MO_INC = 4'h0, MO_DEC = 4'h1, MO_COM = 4'h2, MO_LSR = 4'h3,
        MO_PUSH = 4'h4, MO_POP = 4'h5, MO_CALL_IND = 4'h6, MO_RET_SUB = 4'h7,
        MO_RET_INT = 4'h8, MO_JMP = 4'h9, MO_BRSET = 4'ha, MO_WR_STK_LO = 4'hb,
        MO_WR_STK_HI = 4'hc, MO_RD_STK_LO = 4'hd, MO_RD_STK_HI = 4'he, MO_SEI = 4'hf
    } cdp_misc_t;
endpackage

// ==== test/tb_top.sv ====
// Self-checking testbench for the processor core datapath and stack
`timescale 1ns/1ps
module tb_top;
    import cdp_pkg::*;
    typedef struct packed {
        cdp_rrop_t  op;
        logic [7:0] a;
        logic [7:0] b;
        logic [4:0] rs;
        logic [7:0] res;
        logic [7:0] flg;
    } cdp_row_t;
    logic        ref_clk_i;
    logic        reset_i = 1'b1;
    logic        irq_req_i = 1'b0;
    logic [7:0]  irq_vector_i = 8'h20;
    logic [15:0] prog_addr_o, data_addr_o, stack_pointer_o, prog_data_i;
    logic [7:0]  data_wdata_o, data_rdata_i, status_flag_register_o;
    logic        data_we_o, data_re_o, irq_ack_o;
    logic [15:0] rom [256];
    logic [7:0]  dmem [16384];
    logic [23:0] wlog [$];
    cdp_row_t    rows [16];
    int          err_count = 0;
    int          checks = 0;
    int          n;
    cdp_core dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .prog_addr_o(prog_addr_o),
        .prog_data_i(prog_data_i), .data_addr_o(data_addr_o), .data_wdata_o(data_wdata_o),
        .data_we_o(data_we_o), .data_re_o(data_re_o), .data_rdata_i(data_rdata_i),
        .irq_req_i(irq_req_i), .irq_vector_i(irq_vector_i), .irq_ack_o(irq_ack_o),
        .status_flag_register_o(status_flag_register_o), .stack_pointer_o(stack_pointer_o));
    assign prog_data_i = rom[prog_addr_o[7:0]];
    // Unselected read bus shows inverted data so a stray capture is caught
    assign data_rdata_i = data_re_o ? dmem[data_addr_o[13:0]] : ~dmem[data_addr_o[13:0]];
    always @(posedge ref_clk_i) begin
        if (data_we_o === 1'b1) begin
            dmem[data_addr_o[13:0]] <= data_wdata_o;
            wlog.push_back({data_addr_o, data_wdata_o});
        end
    end
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Fills program memory with register moves, which leave the flags alone
    task automatic restart();
        for (int i = 0; i < 256; i++) rom[i] = 16'h1c00;
    endtask
    task automatic do_reset();
        @(posedge ref_clk_i);
        #1 reset_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        wlog.delete();
        check({8'h0, prog_addr_o}, 24'h0, "reset fetch address");
        check({8'h0, stack_pointer_o}, 24'h3fff, "reset stack pointer");
        check({14'h0, status_flag_register_o, data_we_o, data_re_o}, 24'h0, "reset outputs");
        reset_i = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(4 * 3000);
        err_count++;
        tally_and_finish();
    end
    initial begin
        rows = '{'{OP_ADD, 8'h80, 8'h80, 5'h10, 8'h00, 8'h1b},
            '{OP_ADC, 8'h01, 8'h02, 5'h10, 8'h03, 8'h00}, '{OP_SUB, 8'h10, 8'h20, 5'h10, 8'hf0, 8'h15},
            '{OP_SBC, 8'h05, 8'h03, 5'h10, 8'h02, 8'h00}, '{OP_AND, 8'hf0, 8'h3c, 5'h10, 8'h30, 8'h00},
            '{OP_OR, 8'h81, 8'h02, 5'h10, 8'h83, 8'h14}, '{OP_XOR, 8'h5a, 8'h5a, 5'h10, 8'h00, 8'h02},
            '{OP_MOV, 8'h12, 8'h34, 5'h10, 8'h34, 8'h00}, '{OP_CMP, 8'h10, 8'h10, 5'h10, 8'h10, 8'h02},
            '{OP_ADDW, 8'hf0, 8'h00, 5'h10, 8'h01, 8'h00}, '{OP_MUL, 8'hff, 8'hff, 5'h01, 8'hfe, 8'h01},
            '{OP_MULS, 8'hff, 8'hff, 5'h00, 8'h01, 8'h00},
            '{OP_MULSU, 8'hff, 8'h02, 5'h01, 8'hff, 8'h01},
            '{OP_FMUL, 8'h40, 8'h40, 5'h01, 8'h20, 8'h00},
            '{OP_FMULS, 8'hc0, 8'h40, 5'h01, 8'he0, 8'h01},
            '{OP_FMULSU, 8'h40, 8'h80, 5'h01, 8'h40, 8'h00}};
        for (int i = 0; i < 16; i++) begin
            restart();
            rom[0] = {8'h70, rows[i].a};
            rom[1] = {8'h71, rows[i].b};
            rom[2] = {2'h0, rows[i].op, 5'h10, 5'h11};
            rom[3] = {6'h24, rows[i].rs, 5'h00};
            do_reset();
            repeat (12) @(posedge ref_clk_i);
            #1;
            check(24'(wlog.size()), 24'h1, "push count");
            check(wlog[0], {16'h3fff, rows[i].res}, rows[i].op.name());
            check({16'h0, status_flag_register_o}, {16'h0, rows[i].flg}, "flags");
            check({8'h0, stack_pointer_o}, 24'h3ffe, "pointer after push");
        end
        // Call, push, pop, push, then park on a two-word jump
        restart();
        rom[0] = 16'h7077;
        rom[1] = 16'hc006;
        rom[2] = 16'h9200;
        rom[3] = 16'h9640;
        rom[4] = 16'h9240;
        rom[5] = 16'ha400;
        rom[6] = 16'h0005;
        rom[8] = 16'h9c00;
        do_reset();
        repeat (30) @(posedge ref_clk_i);
        #1;
        check(24'(wlog.size()), 24'h4, "call write count");
        check(wlog[0], 24'h3fff02, "return low byte");
        check(wlog[1], 24'h3ffe00, "return high byte");
        check(wlog[2], 24'h3fff77, "push after return");
        check(wlog[3], 24'h3fff77, "pop then push");
        check({8'h0, stack_pointer_o}, 24'h3ffe, "pointer after call");
        // Stack moved first; request held off by the enable, then by the low-byte write
        restart();
        rom[0] = 16'h70f0;
        rom[1] = 16'hae00;
        rom[2] = 16'hbc00;
        rom[3] = 16'h8a00;
        rom[32] = 16'hb680;
        rom[33] = 16'h9280;
        rom[34] = 16'ha400;
        rom[35] = 16'h0022;
        irq_req_i = 1'b1;
        do_reset();
        for (n = 0; n < 20 && irq_ack_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
        check(24'(n), 24'h8, "interrupt acknowledge");
        irq_req_i = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1;
        check(wlog[0], 24'h3ff006, "entry low byte");
        check(wlog[1], 24'h3fef00, "entry high byte");
        check(wlog[2], 24'h3feeee, "pointer low byte read");
        check({8'h0, stack_pointer_o}, 24'h3fed, "pointer after entry");
        check({16'h0, status_flag_register_o}, 24'h1, "flags on entry");
        check({10'h0, prog_addr_o[15:2]}, 24'h8, "handler fetch");
        tally_and_finish();
    end
endmodule
